// file: sram_ctrl_regs.svh
// sram_ctrl_regs.svh: widths and field positions of the late-write static RAM core.
// assumes it is included by its bare name, once or many times.
`ifndef SRAM_CTRL_REGS_SVH
`define SRAM_CTRL_REGS_SVH

// ----------------------------------------------------------------------------
// array shape
// ----------------------------------------------------------------------------
`define SRAM_ADDR_W     10
`define SRAM_DEPTH      1024
`define SRAM_LANES      4
`define SRAM_LANE_W     8
`define SRAM_DATA_W     32

// ----------------------------------------------------------------------------
// burst counter field, low address bits
// ----------------------------------------------------------------------------
`define SRAM_BURST_W    2
`define SRAM_BURST_LSB  0
`define SRAM_BURST_MSB  1
`define SRAM_BURST_ONE  2'h1
`define SRAM_BURST_ZERO 2'h0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define SRAM_ADDR_RST   10'h000
`define SRAM_DATA_RST   32'h0000_0000
`define SRAM_LANES_RST  4'h0

`endif

// file: sram_ctrl_pkg.sv
// sram_ctrl_pkg: types shared by the late-write static RAM core.
// assumes sram_ctrl_regs.svh is on the include path.
`include "sram_ctrl_regs.svh"

package sram_ctrl_pkg;

    // ------------------------------------------------------------------------
    // types
    // ------------------------------------------------------------------------
    typedef enum logic [1:0] {
        OP_DESELECT,
        OP_READ,
        OP_WRITE
    } op_e;

    typedef logic [`SRAM_ADDR_W-1:0]  addr_t;
    typedef logic [`SRAM_DATA_W-1:0]  data_t;
    typedef logic [`SRAM_LANES-1:0]   lanes_t;
    typedef logic [`SRAM_BURST_W-1:0] burst_t;

endpackage : sram_ctrl_pkg

// file: sram_lane_mem.sv
// sram_lane_mem: storage array with per-lane write enables and registered read data.
// assumes one clock; the enable freezes both ports; read data holds when not read.
`include "sram_ctrl_regs.svh"

module sram_lane_mem (
    // clock and enable
    input  wire logic                 core_clk,
    input  wire logic                 en,
    // read port
    input  wire logic                 rd_en,
    input  wire sram_ctrl_pkg::addr_t rd_addr,
    output      sram_ctrl_pkg::data_t rd_data,
    // write port
    input  wire logic                 wr_en,
    input  wire sram_ctrl_pkg::addr_t wr_addr,
    input  wire sram_ctrl_pkg::lanes_t wr_lanes,
    input  wire sram_ctrl_pkg::data_t wr_data
);
    import sram_ctrl_pkg::*;

    // ------------------------------------------------------------------------
    // array
    // ------------------------------------------------------------------------
    data_t mem_q [`SRAM_DEPTH];
    data_t rd_data_q;

    assign rd_data = rd_data_q;

    // lanes with their enable low are left untouched
    always_ff @(posedge core_clk) begin
        if (en && wr_en) begin
            for (int i = 0; i < `SRAM_LANES; i++) begin
                if (wr_lanes[i]) begin
                    mem_q[wr_addr][i*`SRAM_LANE_W +: `SRAM_LANE_W] <= wr_data[i*`SRAM_LANE_W +: `SRAM_LANE_W];
                end
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (en && rd_en) begin
            rd_data_q <= mem_q[rd_addr];
        end
    end

endmodule : sram_lane_mem

// file: sram_late_write_ctrl.sv
// sram_late_write_ctrl: command decode, burst counter and data pipelines of a
// synchronous late-write static RAM, pipelined or flow-through.
// assumes the bus master runs on core_clk; sleep and mode pins may be asynchronous.
`include "sram_ctrl_regs.svh"

module sram_late_write_ctrl (
    // clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  arst_n,
    input  wire logic                  clk_en,
    // synchronous command pins
    input  wire logic                  clk_gate_n,
    input  wire logic                  burst_step_n_load,
    input  wire logic                  select_low_1,
    input  wire logic                  select_high_2,
    input  wire logic                  select_low_3,
    input  wire logic                  write_n,
    input  wire sram_ctrl_pkg::addr_t  addr,
    // byte lane write enables, active low
    input  wire logic                  lane0_write_n,
    input  wire logic                  lane1_write_n,
    input  wire logic                  lane2_write_n,
    input  wire logic                  lane3_write_n,
    // asynchronous and mode pins
    input  wire logic                  output_enable_n,
    input  wire logic                  sleep_req,
    input  wire logic                  flow_through_sel_n,
    input  wire logic                  linear_order_n,
    // data pins, three signals of the two-way bus
    input  wire sram_ctrl_pkg::data_t  dq_in,
    output      sram_ctrl_pkg::data_t  dq_out,
    output      logic                  dq_oe,
    // status
    output      logic                  asleep
);
    import sram_ctrl_pkg::*;

    // ------------------------------------------------------------------------
    // pin synchronisers for asynchronous inputs
    // ------------------------------------------------------------------------
    logic oe_n_meta_q;
    logic oe_n_sync_q;
    logic sleep_meta_q;
    logic sleep_sync_q;
    logic flow_n_meta_q;
    logic flow_n_sync_q;
    logic order_meta_q;
    logic order_sync_q;
    logic oe_n_s;
    logic sleep_s;
    logic flow_s;
    logic interleave_s;

    // reset value matches the pulled default: pipelined
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flow_n_meta_q <= 1'b1;
            flow_n_sync_q <= 1'b1;
        end else if (clk_en) begin
            flow_n_meta_q <= flow_through_sel_n;
            flow_n_sync_q <= flow_n_meta_q;
        end
    end

    // reset value matches the pulled default: awake
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sleep_meta_q <= 1'b0;
            sleep_sync_q <= 1'b0;
        end else if (clk_en) begin
            sleep_meta_q <= sleep_req;
            sleep_sync_q <= sleep_meta_q;
        end
    end

    // output enable starts off so the bus is released from reset
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            oe_n_meta_q <= 1'b1;
            oe_n_sync_q <= 1'b1;
        end else if (clk_en) begin
            oe_n_meta_q <= output_enable_n;
            oe_n_sync_q <= oe_n_meta_q;
        end
    end

    // burst order starts linear
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            order_meta_q <= 1'b0;
            order_sync_q <= 1'b0;
        end else if (clk_en) begin
            order_meta_q <= linear_order_n;
            order_sync_q <= order_meta_q;
        end
    end

    assign oe_n_s       = oe_n_sync_q;
    assign interleave_s = order_sync_q;
    assign flow_s       = ~flow_n_sync_q;

    // second sync stage lands two cycles after the request
    assign sleep_s = sleep_sync_q;
    assign asleep  = sleep_s;

    // ------------------------------------------------------------------------
    // edge qualification
    // ------------------------------------------------------------------------
    logic step;

    // gate high, enable low or asleep: nothing moves
    assign step = clk_en & ~clk_gate_n & ~sleep_s;

    // ------------------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------------------
    op_e    last_op_q;
    op_e    cur_op;
    logic   selected;
    logic   loading;
    lanes_t lanes;

    // pins below are only used at taken rising edges
    // all three selects must be active
    assign selected = ~select_low_1 & select_high_2 & ~select_low_3;
    // load low brings in a fresh address
    assign loading  = ~burst_step_n_load;

    // lanes enabled independently, active low at the pins
    assign lanes = {~lane3_write_n, ~lane2_write_n, ~lane1_write_n, ~lane0_write_n};

    always_comb begin
        cur_op = OP_DESELECT;
        if (loading) begin
            if (!selected) begin
                cur_op = OP_DESELECT;
            end else if (write_n) begin
                // selected load with store request high reads
                cur_op = OP_READ;
            end else begin
                cur_op = OP_WRITE;
            end
        end else begin
            // continue repeats the last operation, selects ignored
            // after a deselect the continue stays deselected
            cur_op = last_op_q;
        end
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            last_op_q <= OP_DESELECT;
        end else if (step) begin
            last_op_q <= cur_op;
        end
    end

    // ------------------------------------------------------------------------
    // burst address counter
    // ------------------------------------------------------------------------
    addr_t  base_addr_q;
    burst_t burst_cnt_q;
    burst_t next_cnt;
    burst_t low_bits;
    addr_t  access_addr;

    // counter advances on every continue cycle
    assign next_cnt = loading ? `SRAM_BURST_ZERO : burst_t'(burst_cnt_q + `SRAM_BURST_ONE);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            base_addr_q <= `SRAM_ADDR_RST;
            burst_cnt_q <= `SRAM_BURST_ZERO;
        end else if (step) begin
            if (loading) begin
                base_addr_q <= addr;
            end
            burst_cnt_q <= next_cnt;
        end
    end

    // linear add or xor interleave, wrapping after four
    always_comb begin
        low_bits = base_addr_q[`SRAM_BURST_MSB:`SRAM_BURST_LSB];
        if (interleave_s) begin
            low_bits = base_addr_q[`SRAM_BURST_MSB:`SRAM_BURST_LSB] ^ next_cnt;
        end else begin
            low_bits = burst_t'(base_addr_q[`SRAM_BURST_MSB:`SRAM_BURST_LSB] + next_cnt);
        end
    end

    // a load uses the external address this very edge
    always_comb begin
        if (loading) begin
            access_addr = addr;
        end else begin
            access_addr = {base_addr_q[`SRAM_ADDR_W-1:`SRAM_BURST_W], low_bits};
        end
    end

    // ------------------------------------------------------------------------
    // write pipeline
    // ------------------------------------------------------------------------
    logic   wr1_v_q;
    addr_t  wr1_addr_q;
    lanes_t wr1_lanes_q;
    logic   wr2_v_q;
    addr_t  wr2_addr_q;
    lanes_t wr2_lanes_q;
    logic   mem_wr_en;
    addr_t  mem_wr_addr;
    lanes_t mem_wr_lanes;

    // address, control and lanes registered at the command edge
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr1_v_q     <= 1'b0;
            wr1_addr_q  <= `SRAM_ADDR_RST;
            wr1_lanes_q <= `SRAM_LANES_RST;
        end else if (step) begin
            wr1_v_q     <= (cur_op == OP_WRITE);
            wr1_addr_q  <= access_addr;
            wr1_lanes_q <= lanes;
        end
    end

    // second stage only matters for the double late write
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr2_v_q     <= 1'b0;
            wr2_addr_q  <= `SRAM_ADDR_RST;
            wr2_lanes_q <= `SRAM_LANES_RST;
        end else if (step) begin
            wr2_v_q     <= wr1_v_q;
            wr2_addr_q  <= wr1_addr_q;
            wr2_lanes_q <= wr1_lanes_q;
        end
    end

    // flow-through stores the data at the second edge
    // pipelined stores the data at the third edge
    // a write with no lanes active stores nothing
    always_comb begin
        if (flow_s) begin
            mem_wr_en    = wr1_v_q;
            mem_wr_addr  = wr1_addr_q;
            mem_wr_lanes = wr1_lanes_q;
        end else begin
            mem_wr_en    = wr2_v_q;
            mem_wr_addr  = wr2_addr_q;
            mem_wr_lanes = wr2_lanes_q;
        end
    end

    // ------------------------------------------------------------------------
    // read pipeline
    // ------------------------------------------------------------------------
    logic  rd1_v_q;
    logic  rd2_v_q;
    data_t mem_rd_data;
    data_t out_reg_q;
    logic  rd_now;

    assign rd_now = (cur_op == OP_READ);

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            rd1_v_q <= 1'b0;
            rd2_v_q <= 1'b0;
        end else if (step) begin
            rd1_v_q <= rd_now;
            rd2_v_q <= rd1_v_q;
        end
    end

    // output register adds the second cycle of read latency
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            out_reg_q <= `SRAM_DATA_RST;
        end else if (step) begin
            out_reg_q <= mem_rd_data;
        end
    end

    sram_lane_mem u_mem (
        .core_clk (core_clk),
        .en       (step),
        .rd_en    (rd_now),
        .rd_addr  (access_addr),
        .rd_data  (mem_rd_data),
        .wr_en    (mem_wr_en),
        .wr_addr  (mem_wr_addr),
        .wr_lanes (mem_wr_lanes),
        .wr_data  (dq_in)
    );

    // ------------------------------------------------------------------------
    // data output drivers
    // ------------------------------------------------------------------------
    logic read_out;

    // flow-through presents the array read register directly
    always_comb begin
        if (flow_s) begin
            dq_out = mem_rd_data;
        end else begin
            dq_out = out_reg_q;
        end
    end

    // only read cycles drive, so writes are off regardless of enable
    // stalled pipeline flags hold; output enable, sleep and the mode pin can still change the bus only while clk_en is high
    always_comb begin
        if (flow_s) begin
            read_out = rd1_v_q;
        end else begin
            read_out = rd2_v_q;
        end
    end

    // dummy read: output enable high keeps the bus high-z
    // reset clears the read flags, so the bus starts high-z
    // sleep forces high-z while keeping the pipeline
    assign dq_oe = read_out & ~oe_n_s & ~sleep_s;

endmodule : sram_late_write_ctrl

// file: sram_ctrl_sva.sv
// sram_ctrl_sva: port checks of the late-write static RAM core.
// assumes the bench drops clk_en only in the stall test and releases reset on a clock edge.
module sram_ctrl_sva (
    // clock and reset
    input wire logic                 core_clk,
    input wire logic                 arst_n,
    input wire logic                 clk_en,
    // commands
    input wire logic                 clk_gate_n,
    input wire logic                 burst_step_n_load,
    input wire logic                 select_low_1,
    input wire logic                 select_high_2,
    input wire logic                 select_low_3,
    input wire logic                 write_n,
    // mode pins
    input wire logic                 output_enable_n,
    input wire logic                 sleep_req,
    input wire logic                 flow_through_sel_n,
    // outputs
    input wire sram_ctrl_pkg::data_t dq_out,
    input wire logic                 dq_oe,
    input wire logic                 asleep
);
    timeunit 1ns;
    timeprecision 1ps;
    import sram_ctrl_pkg::*;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!arst_n);
    logic       taken;
    logic       sel_off;
    logic       flow_q;
    logic [2:0] cnt_q;
    assign taken = clk_en && !clk_gate_n && !asleep;
    assign sel_off = select_low_1 || !select_high_2 || select_low_3;
    // ------
    // edges the mode pin has stood still with output enable low and sleep low
    // ------
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            flow_q <= 1'b1;
            cnt_q <= 3'h0;
        end else begin
            flow_q <= flow_through_sel_n;
            if (output_enable_n || sleep_req || flow_through_sel_n != flow_q) begin
                cnt_q <= 3'h0;
            end else if (cnt_q != 3'h7) begin
                cnt_q <= cnt_q + 3'h1;
            end
        end
    end
    sequence s_desel;
        taken && !burst_step_n_load && sel_off;
    endsequence
    sequence s_rd;
        taken && !burst_step_n_load && !sel_off && write_n;
    endsequence
    sequence s_wr;
        taken && !burst_step_n_load && !sel_off && !write_n;
    endsequence
    stall_hold_a: assert property (
        clk_en && clk_gate_n |=> $stable(dq_out)) else $error("read data moved on a stalled edge");
    desel_quiet_a: assert property (
        s_desel ##1 (taken && (burst_step_n_load || sel_off)) |=> !dq_oe) else $error("bus driven when deselected");
    write_quiet_a: assert property (
        s_wr ##1 (taken && (burst_step_n_load || !write_n)) |=> !dq_oe) else $error("bus driven in a write");
    sleep_hiz_a: assert property (
        asleep |-> !dq_oe) else $error("bus driven while asleep");
    sleep_enter_a: assert property (
        sleep_req [*4] |-> asleep) else $error("sleep not entered");
    sleep_exit_a: assert property (
        !sleep_req [*4] |-> !asleep) else $error("sleep not left");
    reset_hiz_a: assert property (
        $rose(arst_n) |-> !dq_oe [*2]) else $error("bus driven after reset");
    pipe_lat_a: assert property (
        (flow_through_sel_n && cnt_q > 3'h3) ##0 s_desel ##1 s_rd ##1 taken |-> !dq_oe ##1 dq_oe)
        else $error("pipelined read latency wrong");
    flow_lat_a: assert property (
        (!flow_through_sel_n && cnt_q > 3'h3) ##0 s_desel ##1 s_rd |-> !dq_oe ##1 dq_oe)
        else $error("flow-through read latency wrong");
endmodule : sram_ctrl_sva

bind sram_late_write_ctrl sram_ctrl_sva u_sva (
    .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .clk_gate_n(clk_gate_n),
    .burst_step_n_load(burst_step_n_load), .select_low_1(select_low_1), .select_high_2(select_high_2),
    .select_low_3(select_low_3), .write_n(write_n), .output_enable_n(output_enable_n),
    .sleep_req(sleep_req), .flow_through_sel_n(flow_through_sel_n), .dq_out(dq_out), .dq_oe(dq_oe),
    .asleep(asleep)
);

// file: sram_master_model.sv
// sram_master_model: write-data side of the bus master facing the RAM core.
// assumes wr_issue is raised with every write command the bench drives.
module sram_master_model (
    // clock and mode
    input  wire logic                 core_clk,
    input  wire logic                 flow_mode,
    // write schedule
    input  wire logic                 wr_issue,
    input  wire sram_ctrl_pkg::data_t wr_word,
    // data lines toward the core
    output      sram_ctrl_pkg::data_t dq_in
);
    timeunit 1ns;
    timeprecision 1ps;
    import sram_ctrl_pkg::*;
    logic [1:0] due_q = 2'h0;
    data_t      word0_q;
    data_t      word1_q;
    data_t      idle_q = 32'h5A5A_A5A5;
    always_ff @(posedge core_clk) begin
        due_q <= {due_q[0], wr_issue};
        word0_q <= wr_word;
        word1_q <= word0_q;
    end
    // released lines toggle so stale data cannot pass for good data
    always_ff @(posedge core_clk) begin
        idle_q <= ~idle_q;
    end
    assign dq_in = flow_mode ? (due_q[0] ? word0_q : idle_q) : (due_q[1] ? word1_q : idle_q);
endmodule : sram_master_model

// file: tb_top.sv
// tb_top: scenario bench for the late-write static RAM core.
// assumes the checker is bound to the core; clk_en drops only in the stall test.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import sram_ctrl_pkg::*;
    logic core_clk = 1'b0, arst_n = 1'b0, clk_gate_n = 1'b0, burst_step_n_load = 1'b0;
    logic write_n = 1'b1, output_enable_n = 1'b0, sleep_req = 1'b0, flow_through_sel_n = 1'b1;
    logic linear_order_n = 1'b0, wr_issue = 1'b0, dq_oe, asleep, clk_en = 1'b1;
    logic [2:0] sel = 3'b101;
    lanes_t lanes_n = 4'hF;
    addr_t addr = 10'h000;
    data_t wr_word = 32'h0, dq_in, dq_out;
    int error_cnt = 0, samples_checked = 0;

    always #5 core_clk = ~core_clk;

    sram_late_write_ctrl u_dut (
        .core_clk(core_clk), .arst_n(arst_n), .clk_en(clk_en), .clk_gate_n(clk_gate_n),
        .burst_step_n_load(burst_step_n_load), .select_low_1(sel[2]), .select_high_2(sel[1]),
        .select_low_3(sel[0]), .write_n(write_n), .addr(addr), .lane0_write_n(lanes_n[0]),
        .lane1_write_n(lanes_n[1]), .lane2_write_n(lanes_n[2]), .lane3_write_n(lanes_n[3]),
        .output_enable_n(output_enable_n), .sleep_req(sleep_req), .flow_through_sel_n(flow_through_sel_n),
        .linear_order_n(linear_order_n), .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe), .asleep(asleep)
    );
    sram_master_model u_master (
        .core_clk(core_clk), .flow_mode(!flow_through_sel_n), .wr_issue(wr_issue), .wr_word(wr_word),
        .dq_in(dq_in)
    );

    task automatic check(input data_t seen, input data_t exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic issue(input logic st, input logic [2:0] s, input logic wn, input addr_t a,
                         input lanes_t ln, input logic wd, input data_t w);
        @(posedge core_clk);
        burst_step_n_load <= st;
        sel <= s;
        write_n <= wn;
        addr <= a;
        lanes_n <= ln;
        wr_issue <= wd;
        wr_word <= w;
    endtask : issue

    // every new single access starts with load low
    task automatic rd(input addr_t a);
        issue(1'b0, 3'b010, 1'b1, a, 4'hF, 1'b0, 32'h0);
    endtask : rd

    task automatic wr(input addr_t a, input lanes_t ln, input data_t w);
        issue(1'b0, 3'b010, 1'b0, a, ln, 1'b1, w);
    endtask : wr

    task automatic idle(input logic [2:0] s);
        issue(1'b0, s, 1'b1, 10'h3FF, 4'hF, 1'b0, 32'h0);
    endtask : idle

    task automatic t_lanes;
        wr(10'h010, 4'h0, 32'h1122_3344);
        wr(10'h010, 4'hA, 32'hAABB_CCDD);
        wr(10'h010, 4'hF, 32'h5555_5555);
        repeat (2) idle(3'b101);
        rd(10'h010);
        idle(3'b101);
        #1 check(data_t'(dq_oe), 32'h0);
        idle(3'b101);
        #1 check(dq_out, 32'h11BB_33DD);
        $display("lane test done");
    endtask : t_lanes

    task automatic t_burst;
        data_t d[4] = '{32'hA0A0_0000, 32'hA1A1_1111, 32'hA2A2_2222, 32'hA3A3_3333};
        wr(10'h021, 4'h0, d[0]);
        for (int k = 1; k < 4; k++) issue(1'b1, 3'b010, 1'b1, 10'h3FF, 4'h0, 1'b1, d[k]);
        idle(3'b101);
        linear_order_n <= 1'b1;
        repeat (3) idle(3'b101);
        rd(10'h021);
        issue(1'b1, 3'b101, 1'b1, 10'h3FF, 4'hF, 1'b0, 32'h0);
        for (int k = 0; k < 4; k++) begin
            if (k < 2) issue(1'b1, 3'b101, 1'b1, 10'h3FF, 4'hF, 1'b0, 32'h0);
            else idle(3'b101);
            #1 check(dq_out, d[((1 ^ k) + 3) % 4]);
        end
        idle(3'b101);
        linear_order_n <= 1'b0;
        $display("burst test done");
    endtask : t_burst

    task automatic t_stall;
        rd(10'h021);
        idle(3'b101);
        @(posedge core_clk);
        clk_gate_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check(dq_out, 32'hA0A0_0000);
        check(data_t'(dq_oe), 32'h1);
        @(posedge core_clk);
        clk_gate_n <= 1'b0;
        clk_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        #1 check(dq_out, 32'hA0A0_0000);
        check(data_t'(dq_oe), 32'h1);
        @(posedge core_clk);
        clk_en <= 1'b1;
        $display("stall test done");
    endtask : t_stall

    task automatic t_deselect;
        logic [2:0] pat[3] = '{3'b110, 3'b000, 3'b011};
        foreach (pat[i]) begin
            rd(10'h021);
            idle(pat[i]);
            issue(1'b1, 3'b010, 1'b1, 10'h3FF, 4'hF, 1'b0, 32'h0);
            #1 check(data_t'(dq_oe), 32'h1);
            idle(3'b101);
            #1 check(data_t'(dq_oe), 32'h0);
            idle(3'b101);
            #1 check(data_t'(dq_oe), 32'h0);
        end
        idle(3'b101);
        output_enable_n <= 1'b1;
        repeat (3) idle(3'b101);
        rd(10'h021);
        repeat (2) idle(3'b101);
        output_enable_n <= 1'b0;
        #1 check(data_t'(dq_oe), 32'h0);
        $display("deselect test done");
    endtask : t_deselect

    task automatic t_sleep;
        idle(3'b101);
        sleep_req <= 1'b1;
        repeat (2) idle(3'b101);
        #1 check(data_t'(asleep), 32'h1);
        wr(10'h021, 4'h0, 32'hDEAD_BEEF);
        idle(3'b101);
        sleep_req <= 1'b0;
        repeat (4) idle(3'b101);
        rd(10'h021);
        repeat (2) idle(3'b101);
        #1 check(dq_out, 32'hA0A0_0000);
        $display("sleep test done");
    endtask : t_sleep

    task automatic t_flow;
        idle(3'b101);
        flow_through_sel_n <= 1'b0;
        repeat (4) idle(3'b101);
        wr(10'h030, 4'h0, 32'h0F0F_1234);
        idle(3'b101);
        rd(10'h030);
        idle(3'b101);
        #1 check(dq_out, 32'h0F0F_1234);
        check(data_t'(dq_oe), 32'h1);
        idle(3'b101);
        #1 check(data_t'(dq_oe), 32'h0);
        $display("flow-through test done");
    endtask : t_flow

    task automatic report_and_stop;
        $display("checks %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    initial begin
        repeat (5) @(posedge core_clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        #1 check(data_t'(dq_oe), 32'h0);
        check(data_t'(asleep), 32'h0);
        $display("power-up test done");
        t_lanes();
        t_burst();
        t_stall();
        t_deselect();
        t_sleep();
        t_flow();
        report_and_stop();
    end

    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        $display("wrong value at %0t ns: run did not finish", $time);
        report_and_stop();
    end
endmodule : tb_top
